// File: rtl/spc_regs.vh
// Purpose: constants for the serial programming and control block
// Assumes: 32-bit axi4-lite data, byte addresses
// Notes:   guarded header, definitions only
`ifndef SPC_REGS_VH
`define SPC_REGS_VH
`define SPC_OFF_CTRL      6'h00
`define SPC_OFF_STATUS    6'h04
`define SPC_OFF_IRQ_STAT  6'h08
`define SPC_OFF_IRQ_MASK  6'h0c
`define SPC_OFF_FREQ_PRI  6'h10
`define SPC_OFF_FREQ_SEC  6'h14
`define SPC_OFF_REF_WORD  6'h18
`define SPC_OFF_ACNT      6'h1c
`define SPC_CTRL_RST      32'h0000_0000
`define SPC_MASK_RST      4'h0
`define SPC_FREQ_BITS     24
`define SPC_REF_BITS      18
`define SPC_FBUF_W        22
`define SPC_RBUF_W        16
`define SPC_ACNT_W        4
`define SPC_BIT_PD_A      0
`define SPC_BIT_PD_B      1
`define SPC_ADDR_F1       2'b00
`define SPC_ADDR_F2       2'b10
`define SPC_ADDR_ACNT     2'b01
`define SPC_ADDR_REF      2'b11
`define SPC_IRQ_F1        0
`define SPC_IRQ_F2        1
`define SPC_IRQ_REF       2
`define SPC_IRQ_LOCKCHG   3
`define SPC_RESP_OKAY     2'b00
`define SPC_RESP_SLVERR   2'b10
`endif

// File: rtl/spc_serial_ctrl.v
// Purpose: three-wire serial loader, word buffers and detector mode logic
// Assumes: serial clock, enable, data and lock comparator are asynchronous pins
// Notes:   serial clock sampled by aclk; host must keep it below aclk/4
// Operation
// (R01) frequency-word load is exactly 24 bits in one enable window
// (R02) reference-word load is exactly 18 bits in one enable window
// (R03) host programs fully with 3 framed loads, 66 bits total; here the a-count buffer needs a fourth 24-bit load, 90 bits in all
// (R04) host writes unused frequency bit as zero in divide-by-8/9 mode
// (R05) shifter and buffers keep working during power-down
// (R06) control bits 00: compare outputs off, both pumps on
// (R07) control bits 10: compare outputs on, pump 1 off, pump 2 on
// (R08) control bits 01: outputs off, pump 2 on, pump 1 gated by lock
// (R09) control bits 11: outputs on, pump 2 on, pump 1 gated by lock
// (R10) lock indicator low while in lock window, high otherwise
// (R11) gated modes: both pumps on out of lock, pump 1 off after lock
// (R12) host picks a mode keeping pump 1 on when it alone drives
// (R13) shifter copied to addressed buffer on enable falling edge
// (R14) serial words shift most significant bit first
// (R15) last two bits pick buffer: 00 f1, 10 f2, 01 a-count, 11 ref
// (R16) first frequency buffer used while select high, second while low
// (R17) lock comparator result synchronised before gating pump 1
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "spc_regs.vh"
module spc_serial_ctrl #(
  parameter SR_W = 24
) (
  // clock and reset
  input  wire                    aclk,
  input  wire                    aresetn,
  // axi4-lite write address and data
  input  wire [5:0]              s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  // axi4-lite read
  input  wire [5:0]              s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  // three-wire programming pins
  input  wire                    ser_clk,
  input  wire                    ser_data,
  input  wire                    ser_enable,
  // synthesiser control pins
  input  wire                    freq_word_select,
  input  wire                    power_down,
  input  wire                    lock_window_in,
  // outputs
  output reg  [`SPC_FBUF_W-1:0]  active_freq_word,
  output reg  [`SPC_ACNT_W-1:0]  acnt_word,
  output reg  [12:0]             ref_divide,
  output reg                     prescaler_ratio,
  output reg                     vco_compare_out_en,
  output reg                     pump1_en,
  output reg                     pump2_en,
  output reg                     lock_detect_n,
  output wire                    irq
);

  // synchronisers: first stage read only by second
  reg  [5:0]               sync1_reg;
  reg  [5:0]               sync2_reg;
  reg                      sclk_d_reg;
  reg                      sen_d_reg;
  reg  [SR_W-1:0]          shift_reg;
  reg  [5:0]               count_reg;
  reg  [`SPC_FBUF_W-1:0]   freq_word_primary;
  reg  [`SPC_FBUF_W-1:0]   freq_word_secondary;
  reg  [`SPC_RBUF_W-1:0]   ref_word_reg;
  reg  [`SPC_ACNT_W-1:0]   acnt_buf_reg;
  reg  [3:0]               irq_stat_reg;
  reg  [3:0]               irq_mask_reg;
  reg  [3:0]               irq_set_next;
  reg                      lock_prev_reg;
  reg  [31:0]              err_cnt_reg;
  reg                      aw_held_reg;
  reg                      w_held_reg;
  reg  [5:0]               aw_addr_reg;
  reg  [31:0]              w_data_reg;
  reg  [3:0]               w_strb_reg;
  wire                     sclk_s;
  wire                     sdat_s;
  wire                     sen_s;
  wire                     lock_s;
  wire                     fsel_s;
  wire                     pdn_s;
  wire                     sclk_rise;
  wire                     sen_fall;
  wire                     in_lock;
  wire                     detector_ctrl_bit_a;
  wire                     detector_ctrl_bit_b;
  wire [1:0]               dest_addr;
  wire                     dest_addr_bit_low;
  wire                     dest_addr_bit_high;
  wire                     do_write;
  wire [31:0]              wr_merged;

  assign sclk_s    = sync2_reg[0];
  assign sdat_s    = sync2_reg[1];
  assign sen_s     = sync2_reg[2];
  assign lock_s    = sync2_reg[3];
  assign fsel_s    = sync2_reg[4];
  assign pdn_s     = sync2_reg[5];
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sen_fall  = ~sen_s & sen_d_reg;
  assign in_lock   = lock_s; // (R17)

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg  <= 6'h00;
      sync2_reg  <= 6'h00;
      sclk_d_reg <= 1'b0;
      sen_d_reg  <= 1'b0;
    end else begin
      sync1_reg  <= {power_down, freq_word_select, lock_window_in, ser_enable, ser_data, ser_clk};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sclk_s;
      sen_d_reg  <= sen_s;
    end
  end

  // destination bits are the last two shifted in
  assign dest_addr_bit_low  = shift_reg[0];
  assign dest_addr_bit_high = shift_reg[1];
  assign dest_addr          = {dest_addr_bit_high, dest_addr_bit_low};

  // length check: a wrong count drops the load rather than corrupt a buffer
  function len_ok;
    input [1:0] addr;
    input [5:0] cnt;
    begin
      if (addr == `SPC_ADDR_REF) begin
        len_ok = (cnt == 6'd`SPC_REF_BITS);
      end else begin
        len_ok = (cnt == 6'd`SPC_FREQ_BITS);
      end
    end
  endfunction

  // power_down deliberately not used here so loads keep working
  always @(posedge aclk) begin // (R05)
    if (!aresetn) begin
      shift_reg           <= {SR_W{1'b0}};
      count_reg           <= 6'd0;
      freq_word_primary   <= {`SPC_FBUF_W{1'b0}};
      freq_word_secondary <= {`SPC_FBUF_W{1'b0}};
      ref_word_reg        <= {`SPC_RBUF_W{1'b0}};
      acnt_buf_reg        <= {`SPC_ACNT_W{1'b0}};
    end else begin
      if (sen_s && sclk_rise) begin
        shift_reg <= {shift_reg[SR_W-2:0], sdat_s}; // (R14)
        if (count_reg != 6'h3f) begin
          count_reg <= count_reg + 6'd1;
        end
      end
      if (sen_fall) begin // (R13)
        count_reg <= 6'd0;
        if (len_ok(dest_addr, count_reg)) begin // (R01) (R02)
          case (dest_addr) // (R15)
            `SPC_ADDR_F1: begin
              freq_word_primary <= shift_reg[SR_W-1:2];
            end
            `SPC_ADDR_F2: begin
              freq_word_secondary <= shift_reg[SR_W-1:2];
            end
            `SPC_ADDR_ACNT: begin
              acnt_buf_reg <= shift_reg[5:2];
            end
            `SPC_ADDR_REF: begin
              ref_word_reg <= shift_reg[`SPC_RBUF_W+1:2];
            end
            default: begin
              acnt_buf_reg <= acnt_buf_reg;
            end
          endcase
        end
      end
    end
  end

  // reference word: bits 1:0 detector control, 2 prescaler, 15:3 divider
  assign detector_ctrl_bit_a = ref_word_reg[`SPC_BIT_PD_A];
  assign detector_ctrl_bit_b = ref_word_reg[`SPC_BIT_PD_B];

  always @(posedge aclk) begin
    if (!aresetn) begin
      active_freq_word   <= {`SPC_FBUF_W{1'b0}};
      acnt_word          <= {`SPC_ACNT_W{1'b0}};
      ref_divide         <= 13'h0000;
      prescaler_ratio    <= 1'b0;
      vco_compare_out_en <= 1'b0;
      pump1_en           <= 1'b1;
      pump2_en           <= 1'b1;
      lock_detect_n      <= 1'b1;
    end else begin
      active_freq_word <= fsel_s ? freq_word_primary
                                           : freq_word_secondary; // (R16)
      acnt_word        <= acnt_buf_reg;
      ref_divide       <= ref_word_reg[15:3];
      prescaler_ratio  <= ref_word_reg[2];
      lock_detect_n    <= ~in_lock; // (R10)
      pump2_en         <= 1'b1;
      case ({detector_ctrl_bit_a, detector_ctrl_bit_b})
        2'b00: begin
          vco_compare_out_en <= 1'b0; // (R06)
          pump1_en           <= 1'b1;
        end
        2'b10: begin
          vco_compare_out_en <= 1'b1; // (R07)
          pump1_en           <= 1'b0;
        end
        2'b01: begin
          vco_compare_out_en <= 1'b0; // (R08)
          pump1_en           <= ~in_lock; // (R11)
        end
        2'b11: begin
          vco_compare_out_en <= 1'b1; // (R09)
          pump1_en           <= ~in_lock; // (R11)
        end
        default: begin
          vco_compare_out_en <= 1'b0;
          pump1_en           <= 1'b1;
        end
      endcase
    end
  end

  // axi4-lite slave, single outstanding write and read
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write      = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_merged     = {w_strb_reg[3] ? w_data_reg[31:24] : 8'h00,
                          w_strb_reg[2] ? w_data_reg[23:16] : 8'h00,
                          w_strb_reg[1] ? w_data_reg[15:8]  : 8'h00,
                          w_strb_reg[0] ? w_data_reg[7:0]   : 8'h00};

  always @* begin
    irq_set_next = 4'h0;
    if (sen_fall && len_ok(dest_addr, count_reg)) begin
      irq_set_next[`SPC_IRQ_F1]  = (dest_addr == `SPC_ADDR_F1);
      irq_set_next[`SPC_IRQ_F2]  = (dest_addr == `SPC_ADDR_F2);
      irq_set_next[`SPC_IRQ_REF] = (dest_addr == `SPC_ADDR_REF);
    end
    irq_set_next[`SPC_IRQ_LOCKCHG] = (in_lock != lock_prev_reg);
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 6'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPC_RESP_OKAY;
      irq_stat_reg  <= 4'h0;
      irq_mask_reg  <= `SPC_MASK_RST;
      lock_prev_reg <= 1'b0;
      err_cnt_reg   <= `SPC_CTRL_RST;
    end else begin
      lock_prev_reg <= in_lock;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      // set wins over write-one-to-clear
      irq_stat_reg <= irq_stat_reg | irq_set_next;
      if (sen_fall && !len_ok(dest_addr, count_reg)) begin
        err_cnt_reg <= err_cnt_reg + 32'd1;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SPC_RESP_OKAY;
        case (aw_addr_reg)
          `SPC_OFF_IRQ_STAT: begin
            irq_stat_reg <= (irq_stat_reg & ~wr_merged[3:0]) | irq_set_next;
          end
          `SPC_OFF_IRQ_MASK: begin
            if (w_strb_reg[0]) begin
              irq_mask_reg <= w_data_reg[3:0];
            end
          end
          `SPC_OFF_CTRL: begin
            if (wr_merged != 32'h0000_0000) begin
              err_cnt_reg <= 32'h0000_0000;
            end
          end
          `SPC_OFF_STATUS, `SPC_OFF_FREQ_PRI, `SPC_OFF_FREQ_SEC,
          `SPC_OFF_REF_WORD, `SPC_OFF_ACNT: begin
            s_axi_bresp <= `SPC_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `SPC_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SPC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SPC_RESP_OKAY;
        case (s_axi_araddr)
          `SPC_OFF_CTRL: begin
            s_axi_rdata <= err_cnt_reg;
          end
          `SPC_OFF_STATUS: begin
            s_axi_rdata <= {26'h0, pdn_s, fsel_s, sen_s,
                            pump1_en, vco_compare_out_en, in_lock};
          end
          `SPC_OFF_IRQ_STAT: begin
            s_axi_rdata <= {28'h0, irq_stat_reg};
          end
          `SPC_OFF_IRQ_MASK: begin
            s_axi_rdata <= {28'h0, irq_mask_reg};
          end
          `SPC_OFF_FREQ_PRI: begin
            s_axi_rdata <= {10'h0, freq_word_primary};
          end
          `SPC_OFF_FREQ_SEC: begin
            s_axi_rdata <= {10'h0, freq_word_secondary};
          end
          `SPC_OFF_REF_WORD: begin
            s_axi_rdata <= {16'h0, ref_word_reg};
          end
          `SPC_OFF_ACNT: begin
            s_axi_rdata <= {28'h0, acnt_buf_reg};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SPC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// File: tb/spc_host_model.sv
// Purpose: host side of the three-wire programming link
// Assumes: 320 ns serial clock, still outside frames
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/1ps
module spc_host_model (
  // link pins
  output logic ser_clk,
  output logic ser_data,
  output logic ser_enable
);
  initial begin
    ser_clk = 0;
    ser_data = 0;
    ser_enable = 0;
  end
  // one framed load of the low n bits of w; 7 ns skew keeps edges off aclk
  task automatic load(input logic [23:0] w, input int n);
    #7 ser_enable = 1;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = w[i];
      #160 ser_clk = 1;
      #160 ser_clk = 0;
    end
    #160 ser_enable = 0;
    ser_data = ~ser_data;
    #400;
  endtask
endmodule

// File: tb/spc_serial_ctrl_assertions.sv
// Purpose: port-level checks for the serial programming block
// Assumes: single aclk domain, reset active low
// Notes:   lock path takes 3 edges, so a 4-cycle settle is allowed
`timescale 1ns/1ps
`include "spc_regs.vh"
module spc_serial_ctrl_assertions (
  // clock and reset
  input wire aclk, input wire aresetn,
  // axi4-lite handshakes
  input wire s_axi_awvalid, input wire s_axi_awready, input wire s_axi_wvalid,
  input wire s_axi_wready, input wire [1:0] s_axi_bresp, input wire s_axi_bvalid,
  input wire s_axi_bready, input wire s_axi_arvalid, input wire s_axi_arready,
  input wire [31:0] s_axi_rdata, input wire s_axi_rvalid, input wire s_axi_rready,
  // pins and outputs
  input wire ser_enable, input wire freq_word_select, input wire lock_window_in,
  input wire [`SPC_FBUF_W-1:0] active_freq_word, input wire [`SPC_ACNT_W-1:0] acnt_word,
  input wire [12:0] ref_divide, input wire vco_compare_out_en, input wire pump1_en,
  input wire pump2_en, input wire lock_detect_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence lock_settled;
    $stable(lock_window_in) [*4];
  endsequence
  sequence frame_open;
    (ser_enable && $stable(freq_word_select)) [*8];
  endsequence
  lock_track_a: assert property (lock_settled |-> lock_detect_n == !lock_window_in)
    else $error("lock indicator wrong");
  pump1_gate_a: assert property (!pump1_en && !vco_compare_out_en |-> !lock_detect_n)
    else $error("pump 1 off out of lock");
  pump2_on_a: assert property (pump2_en)
    else $error("pump 2 off");
  buf_hold_a: assert property (frame_open |-> $stable({active_freq_word, acnt_word, ref_divide}))
    else $error("buffer changed inside frame");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
endmodule
bind spc_serial_ctrl spc_serial_ctrl_assertions spc_serial_ctrl_assertions_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .ser_enable(ser_enable), .freq_word_select(freq_word_select),
  .lock_window_in(lock_window_in), .active_freq_word(active_freq_word), .acnt_word(acnt_word),
  .ref_divide(ref_divide), .vco_compare_out_en(vco_compare_out_en), .pump1_en(pump1_en),
  .pump2_en(pump2_en), .lock_detect_n(lock_detect_n));

// File: tb/spc_serial_ctrl_tb.sv
// Purpose: self-checking bench for the serial programming block
// Assumes: 25 MHz aclk, host model drives the three-wire link
// Notes:   master offers bready or rready together with each request
`timescale 1ns/1ps
`include "spc_regs.vh"
module spc_serial_ctrl_tb;
  logic aclk = 0, aresetn = 0, fsel = 1, pdn = 0, lock = 0;
  logic [5:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, q;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, comp, p1, p2, lkn, psr;
  logic [1:0] bresp, rresp, rs;
  logic ser_clk, ser_data, ser_enable;
  logic [21:0] afw;
  logic [3:0] acnt;
  logic [12:0] rdiv;
  int err_total = 0;
  int compares = 0;
  spc_host_model spc_host_model_i (.ser_clk(ser_clk), .ser_data(ser_data),
    .ser_enable(ser_enable));
  spc_serial_ctrl spc_serial_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ser_clk(ser_clk), .ser_data(ser_data), .ser_enable(ser_enable),
    .freq_word_select(fsel), .power_down(pdn), .lock_window_in(lock),
    .active_freq_word(afw), .acnt_word(acnt), .ref_divide(rdiv), .prescaler_ratio(psr),
    .vco_compare_out_en(comp), .pump1_en(p1), .pump2_en(p2), .lock_detect_n(lkn), .irq(irq));
  task automatic conclude;
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // one axi4-lite access; w selects write
  task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic [1:0] rr);
    logic hs;
    hs = 0;
    rq = 0;
    rr = 0;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
    end else begin
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
    end
    // each channel released at the edge its ready is sampled high
    for (int n = 0; n < 40 && !hs; n++) begin
      @(posedge aclk);
      if (w && awready) awvalid <= 0;
      if (w && wready) wvalid <= 0;
      if (!w && arready) arvalid <= 0;
      if (w ? bvalid : rvalid) begin
        hs = 1;
        rq = rdata;
        rr = w ? bresp : rresp;
        bready <= 0;
        rready <= 0;
      end
    end
    if (!hs) begin
      err_total++;
      conclude;
    end
    @(negedge aclk);
  endtask
  task automatic t_freq;
    @(posedge aclk);
    pdn <= 1;
    spc_host_model_i.load({22'h2a5c3b, `SPC_ADDR_F1}, 24);
    spc_host_model_i.load({22'h15a3c4, `SPC_ADDR_F2}, 24);
    wt(1);
    chk("primary", afw, 22'h2a5c3b);
    @(posedge aclk);
    fsel <= 0;
    wt(4);
    chk("secondary", afw, 22'h15a3c4);
    bus(0, `SPC_OFF_IRQ_STAT, 0, q, rs);
    chk("irq_stat", q, 32'h3);
    chk("irq_masked", irq, 0);
    bus(1, `SPC_OFF_IRQ_MASK, 32'h1, q, rs);
    wt(1);
    chk("irq_on", irq, 1);
    bus(1, `SPC_OFF_IRQ_STAT, 32'h1, q, rs);
    wt(1);
    chk("irq_clr", irq, 0);
    bus(0, 6'h20, 0, q, rs);
    chk("unmapped", rs, `SPC_RESP_SLVERR);
    @(posedge aclk);
    pdn <= 0;
    fsel <= 1;
  endtask
  // wrong bit counts must leave buffers alone
  task automatic t_short;
    spc_host_model_i.load({22'h0f0f0f, `SPC_ADDR_F1}, 23);
    spc_host_model_i.load({6'h0, 16'h1234, `SPC_ADDR_REF}, 24);
    wt(1);
    chk("short_f1", afw, 22'h2a5c3b);
    chk("long_ref", rdiv, 13'h0);
    bus(0, `SPC_OFF_CTRL, 0, q, rs);
    chk("drop_count", q, 32'h2);
    bus(0, `SPC_OFF_IRQ_STAT, 0, q, rs);
    chk("no_event", q, 32'h2);
  endtask
  task automatic t_modes;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      spc_host_model_i.load({6'h0, 13'h1a5, 1'b1, m[1], m[0], `SPC_ADDR_REF}, 18);
      for (int k = 0; k < 2; k++) begin
        @(posedge aclk);
        lock <= k[0];
        wt(4);
        chk("compare", comp, m[0]);
        chk("pump1", p1, m[1] ? !k[0] : !m[0]);
        chk("pump2", p2, 1);
        chk("lock_n", lkn, !k[0]);
      end
    end
    chk("ref_div", rdiv, 13'h1a5);
    chk("prescale", psr, 1);
    spc_host_model_i.load({18'h0, 4'ha, `SPC_ADDR_ACNT}, 24);
    wt(1);
    chk("acount", acnt, 4'ha);
    // unused counter bit left zero while the prescaler bit is set
    spc_host_model_i.load({22'h1a5c3a, `SPC_ADDR_F1}, 24);
    wt(1);
    chk("f1_div89", afw, 22'h1a5c3a);
    // pump 1 alone drives: mode kept continuous even while in lock
    spc_host_model_i.load({6'h0, 13'h1a5, 1'b1, 2'b00, `SPC_ADDR_REF}, 18);
    wt(1);
    chk("pump1_only", p1, 1);
  endtask
  initial begin
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_freq;
    t_short;
    t_modes;
    conclude;
  end
endmodule
